// ---- hdl/cpu_ras_error_recovery.sv ----
`timescale 1ns/1ps
// Operation
// - Correct single-bit errors in first-level cache data and second-level data and tags, pass on.
// - Rewrite a corrected cache line with the corrected word.
// - Rewrite a faulty second-level tag with its failing bit inverted.
// - Instruction data parity error: invalidate entry, refetch as miss.
// - Duplicated tag copy error notifies other copy: invalidate or write back.
// - Branch history parity only forces mispredict recovery; parity just logged.
// - Translation buffer parity error invalidates that entry.
// - Count errors per unit; at threshold detach the failing way.
// - Flush dirty lines of a data or second-level way before detaching.
// - Correct single memory errors; interrupt on uncorrectable ones.
// - Record address and error type of memory errors for software.
// - Mark uncorrectable memory data with a source mark and special check.
// - Marked errors are recognised as upstream and not logged again.
// - Register parity errors detected; window copy reloaded from window registers.
// - Check operand parity, predicted result parity, multiplier residue.
// - Update-buffer parity travels unchanged into register file write.
// - Hang detector flags long completion stall as an error.
// - Hang, execution, register/update-buffer parity and uncorrectable cache errors cancel all in-flight instructions.
// - Retry one instruction at a time, back to normal on success.
// - After a threshold of failed retries, interrupt software.
// - Reported errors get a severity and per-source log entry; traps only on failed retries and uncorrectable memory errors.
// - Suppress mode blocks cancel, retry, degrade and traps for dumps.
module cpu_ras_error_recovery #(
	parameter int         HANG_CYCLES       = ras_pkg::HANG_DEFAULT,
	parameter int         DEGRADE_THRESHOLD = ras_pkg::DEGRADE_DEFAULT,
	parameter int         RETRY_THRESHOLD   = ras_pkg::RETRY_DEFAULT,
	parameter logic [7:0] MARK_SOURCE_ID    = ras_pkg::MARK_SOURCE_DEFAULT
) (
	input  wire logic                                    core_clk,
	input  wire logic                                    reset,
	input  wire logic                                    clk_en,
	input  wire logic                                    suppress_mode,
	input  wire ras_pkg::ecc_word_t [ras_pkg::N_CH-1:0]  ecc_in,
	output ras_pkg::ecc_result_t    [ras_pkg::N_CH-1:0]  ecc_out,
	output ras_pkg::ecc_word_t      [ras_pkg::N_CH-1:0]  rewrite,
	input  wire ras_pkg::par_event_t                     par_in,
	output ras_pkg::recover_t                            recover,
	input  wire ras_pkg::exec_check_t                    exec_in,
	input  wire ras_pkg::result_t                        ub_result,
	output ras_pkg::result_t                             rf_write,
	input  wire logic                                    commit,
	input  wire logic                                    busy,
	input  wire logic [ras_pkg::N_UNIT-1:0]              flush_done,
	output logic      [ras_pkg::N_UNIT-1:0]              flush_req,
	output logic [ras_pkg::N_UNIT-1:0][ras_pkg::WAY_W-1:0] flush_way,
	output logic [ras_pkg::N_UNIT-1:0][ras_pkg::N_WAY-1:0] way_off,
	output logic                                         cancel_all,
	output logic                                         single_step,
	output ras_pkg::err_info_t                           err_info,
	input  wire logic                                    err_info_clear,
	output logic                                         mem_irq,
	output ras_pkg::trap_t                               trap,
	input  wire logic [ras_pkg::SRC_W-1:0]               log_rd_idx,
	output ras_pkg::log_entry_t                          log_rd_data
);
	import ras_pkg::*;

	localparam int RCNT_W = $clog2(RETRY_THRESHOLD + 1);
	localparam int HCNT_W = $clog2(HANG_CYCLES + 1);

	function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
		logic [CHK_W-1:0] c;
		int               k;
		c = '0;
		k = 0;
		for (int p = 1; p <= CW_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int b = 0; b < HAM_W; b++) begin
					if (p[b])
						c[b] = c[b] ^ d[k];
				end
				k++;
			end
		end
		c[HAM_W] = ^{d, c[HAM_W-1:0]};
		return c;
	endfunction

	// Flips the data bit that the syndrome points at; check-bit hits pass
	function automatic logic [DATA_W-1:0] ecc_fix(input logic [DATA_W-1:0] d,
		input logic [HAM_W-1:0] syn);
		logic [DATA_W-1:0] r;
		int                k;
		r = d;
		k = 0;
		for (int p = 1; p <= CW_LEN; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (syn == HAM_W'(p))
					r[k] = ~d[k];
				k++;
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] mod3(input logic [DATA_W-1:0] v);
		int s;
		s = 0;
		for (int i = 0; i < DATA_W; i++) begin
			if (v[i])
				s = s + ((i % 2 == 1) ? 2 : 1);
		end
		return 2'(s % 3);
	endfunction

	ecc_result_t [N_CH-1:0]     next_ecc_out;
	ecc_word_t   [N_CH-1:0]     next_rewrite;
	recover_t                   next_recover;
	result_t                    next_rf_write;
	err_info_t                  next_err_info;
	logic                       next_mem_irq;
	trap_t                      next_trap;
	logic [N_UNIT-1:0]          unit_hit;
	logic [N_UNIT-1:0][WAY_W-1:0] unit_way;
	degrade_state_t             dg_state [N_UNIT];
	logic [WAY_W-1:0]           dg_way [N_UNIT];
	logic [N_WAY-1:0]           dg_off [N_UNIT];
	logic                       exec_err;
	logic                       ub_err;
	logic                       det_err;
	logic [SRC_W-1:0]           det_src;
	logic                       mem_dbl;
	retry_state_t               rstate, next_rstate;
	logic [RCNT_W-1:0]          rcnt, next_rcnt;
	logic [HCNT_W-1:0]          hcnt, next_hcnt;
	logic                       hang, next_hang;
	logic [N_SRC-1:0]           src_hit;
	severity_t                  src_sev [N_SRC];
	logic                       log_we;
	logic [SRC_W-1:0]           log_sel;
	log_entry_t                 log_wdata;

	for (genvar ch = 0; ch < N_CH; ch++) begin : g_ecc
		always_comb begin
			logic [CHK_W-1:0]  gen;
			logic [HAM_W-1:0]  syn;
			logic              odd;
			logic [DATA_W-1:0] fixed;
			gen = ecc_gen(ecc_in[ch].data);
			syn = gen[HAM_W-1:0] ^ ecc_in[ch].check[HAM_W-1:0];
			odd = ^{ecc_in[ch].data, ecc_in[ch].check};
			fixed = ecc_fix(ecc_in[ch].data, syn);
			next_ecc_out[ch] = '0;
			next_ecc_out[ch].valid = ecc_in[ch].valid;
			next_ecc_out[ch].addr = ecc_in[ch].addr;
			next_ecc_out[ch].way = ecc_in[ch].way;
			next_ecc_out[ch].marked = ecc_in[ch].check == MARK_CHECK &&
				ecc_in[ch].data[DATA_W-1:MARK_LOW_W] == MARK_PATTERN;
			next_ecc_out[ch].single = ecc_in[ch].valid && odd &&
				!next_ecc_out[ch].marked;
			next_ecc_out[ch].double = ecc_in[ch].valid &&
				((!odd && syn != '0) || next_ecc_out[ch].marked);
			if (next_ecc_out[ch].single) begin
				next_ecc_out[ch].data = fixed;
				next_ecc_out[ch].check = ecc_gen(fixed);
			end else begin
				next_ecc_out[ch].data = ecc_in[ch].data;
				next_ecc_out[ch].check = ecc_in[ch].check;
			end
			if (ch == CH_MEM && next_ecc_out[ch].double &&
				!next_ecc_out[ch].marked) begin
				next_ecc_out[ch].data = {MARK_PATTERN, MARK_SOURCE_ID};
				next_ecc_out[ch].check = MARK_CHECK;
			end
			// Tag rewrite is the stored word with the failing bit inverted
			next_rewrite[ch] = '0;
			next_rewrite[ch].valid = ch != CH_MEM &&
				next_ecc_out[ch].single;
			next_rewrite[ch].addr = ecc_in[ch].addr;
			next_rewrite[ch].way = ecc_in[ch].way;
			next_rewrite[ch].data = next_ecc_out[ch].data;
			next_rewrite[ch].check = next_ecc_out[ch].check;
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				ecc_out[ch] <= '0;
				rewrite[ch] <= '0;
			end else if (clk_en) begin
				ecc_out[ch] <= next_ecc_out[ch];
				rewrite[ch] <= next_rewrite[ch];
			end
		end
	end

	always_comb begin
		next_recover = '0;
		next_recover.index = par_in.index;
		next_recover.way = par_in.way;
		if (par_in.valid) begin
			unique case (par_in.src)
				PS_L1I_DATA: begin
					next_recover.l1i_inval = 1'b1;
					next_recover.refetch_miss = 1'b1;
				end
				PS_L1I_TAG_A, PS_L1I_TAG_B: begin
					next_recover.tag_notify = par_in.src == PS_L1I_TAG_A ?
						2'b10 : 2'b01;
					next_recover.l1i_inval = 1'b1;
				end
				PS_L1D_TAG_A, PS_L1D_TAG_B: begin
					next_recover.tag_notify = par_in.src == PS_L1D_TAG_A ?
						2'b10 : 2'b01;
					next_recover.l1d_writeback = 1'b1;
				end
				PS_BRANCH: next_recover.mispredict = 1'b1;
				PS_ITLB: next_recover.tlb_inval = 2'b01;
				PS_DTLB: next_recover.tlb_inval = 2'b10;
				PS_WIN_COPY: next_recover.win_reload = 1'b1;
				PS_REGS: ;
				default: ;
			endcase
		end
	end

	always_comb begin
		exec_err = exec_in.valid && (exec_in.a_par != ^exec_in.op_a ||
			exec_in.b_par != ^exec_in.op_b);
		if (exec_in.valid && exec_in.kind == EX_MUL) begin
			if (mod3(exec_in.res) != mod3(DATA_W'(
				{2'b00, mod3(DATA_W'(exec_in.op_a))} *
				{2'b00, mod3(DATA_W'(exec_in.op_b))})))
				exec_err = 1'b1;
		end else if (exec_in.valid && exec_in.res_par != ^exec_in.res) begin
			exec_err = 1'b1;
		end
		next_rf_write = ub_result;
		ub_err = ub_result.valid && ^ub_result.data != ub_result.par;
	end

	always_comb begin
		unit_hit = '0;
		unit_way = '0;
		for (int ch = 0; ch < CH_MEM; ch++) begin
			if (ecc_out[ch].valid && !ecc_out[ch].marked &&
				(ecc_out[ch].single || ecc_out[ch].double)) begin
				unit_hit[ch == CH_L1D ? U_L1D : U_L2] = 1'b1;
				unit_way[ch == CH_L1D ? U_L1D : U_L2] = ecc_out[ch].way;
			end
		end
		if (par_in.valid) begin
			unique case (par_in.src)
				PS_L1I_DATA, PS_L1I_TAG_A, PS_L1I_TAG_B: begin
					unit_hit[U_L1I] = 1'b1;
					unit_way[U_L1I] = par_in.way;
				end
				PS_L1D_TAG_A, PS_L1D_TAG_B: begin
					unit_hit[U_L1D] = 1'b1;
					unit_way[U_L1D] = par_in.way;
				end
				PS_ITLB: begin
					unit_hit[U_ITLB] = 1'b1;
					unit_way[U_ITLB] = par_in.way;
				end
				PS_DTLB: begin
					unit_hit[U_DTLB] = 1'b1;
					unit_way[U_DTLB] = par_in.way;
				end
				default: ;
			endcase
		end
	end

	for (genvar u = 0; u < N_UNIT; u++) begin : g_degrade
		degrade_state_t   next_state;
		logic [CNT_W-1:0] cnt, next_cnt;
		logic [WAY_W-1:0] next_way;
		logic [N_WAY-1:0] next_off;

		always_comb begin
			next_state = dg_state[u];
			next_cnt = cnt;
			next_way = dg_way[u];
			next_off = dg_off[u];
			unique case (dg_state[u])
				DG_COUNT: if (unit_hit[u] && !suppress_mode) begin
					next_way = unit_way[u];
					if (cnt == CNT_W'(DEGRADE_THRESHOLD - 1)) begin
						next_cnt = '0;
						if (u == U_L1D || u == U_L2)
							next_state = DG_FLUSH;
						else
							next_off[unit_way[u]] = 1'b1;
					end else begin
						next_cnt = cnt + 1'b1;
					end
				end
				DG_FLUSH: if (flush_done[u]) begin
					next_off[dg_way[u]] = 1'b1;
					next_state = DG_COUNT;
				end
			endcase
		end

		always_ff @(posedge core_clk) begin
			if (reset) begin
				dg_state[u] <= DG_COUNT;
				cnt <= '0;
				dg_way[u] <= '0;
				dg_off[u] <= '0;
			end else if (clk_en) begin
				dg_state[u] <= next_state;
				cnt <= next_cnt;
				dg_way[u] <= next_way;
				dg_off[u] <= next_off;
			end
		end
	end

	always_comb begin
		for (int u = 0; u < N_UNIT; u++) begin
			flush_req[u] = dg_state[u] == DG_FLUSH;
			flush_way[u] = dg_way[u];
			way_off[u] = dg_off[u];
		end
	end

	// Errors that void the in-flight work; first source wins for the trap
	always_comb begin
		det_err = 1'b1;
		det_src = SRC_W'(SRC_HANG);
		if (hang)
			det_src = SRC_W'(SRC_HANG);
		else if (exec_err)
			det_src = SRC_W'(SRC_EXEC);
		else if (ub_err || (par_in.valid && par_in.src == PS_REGS))
			det_src = SRC_W'(SRC_PAR + int'(PS_REGS));
		else if (ecc_out[CH_L1D].valid && ecc_out[CH_L1D].double)
			det_src = SRC_W'(CH_L1D);
		else if (ecc_out[CH_L2D].valid && ecc_out[CH_L2D].double)
			det_src = SRC_W'(CH_L2D);
		else if (ecc_out[CH_L2T].valid && ecc_out[CH_L2T].double)
			det_src = SRC_W'(CH_L2T);
		else
			det_err = 1'b0;
	end

	always_comb begin
		next_rstate = rstate;
		next_rcnt = rcnt;
		next_trap = '0;
		mem_dbl = ecc_out[CH_MEM].valid && ecc_out[CH_MEM].double &&
			!ecc_out[CH_MEM].marked;
		unique case (rstate)
			RT_RUN: if (det_err && !suppress_mode)
				next_rstate = RT_CANCEL;
			RT_CANCEL: next_rstate = RT_RETRY;
			RT_RETRY: if (det_err && !suppress_mode) begin
				if (rcnt == RCNT_W'(RETRY_THRESHOLD - 1)) begin
					next_rcnt = '0;
					next_rstate = RT_ABORT;
					next_trap = '{1'b1, SEV_REPORTED, det_src};
				end else begin
					next_rcnt = rcnt + 1'b1;
					next_rstate = RT_CANCEL;
				end
			end else if (commit) begin
				next_rcnt = '0;
				next_rstate = RT_RUN;
			end
			RT_ABORT: next_rstate = RT_RUN;
		endcase
		if (mem_dbl && !suppress_mode && !next_trap.valid)
			next_trap = '{1'b1, SEV_FATAL, SRC_W'(CH_MEM)};
		next_mem_irq = mem_dbl;
		next_err_info = err_info;
		if (err_info_clear)
			next_err_info.valid = 1'b0;
		// A new error outranks a clear in the same cycle
		if (ecc_out[CH_MEM].valid && !ecc_out[CH_MEM].marked &&
			(ecc_out[CH_MEM].single || ecc_out[CH_MEM].double))
			next_err_info = '{1'b1, ecc_out[CH_MEM].addr,
				ecc_out[CH_MEM].double};
	end

	assign cancel_all = rstate == RT_CANCEL || rstate == RT_ABORT;
	assign single_step = rstate == RT_RETRY;

	always_comb begin
		next_hcnt = '0;
		next_hang = 1'b0;
		if (busy && !commit && !cancel_all) begin
			if (hcnt == HCNT_W'(HANG_CYCLES - 1))
				next_hang = 1'b1;
			else
				next_hcnt = hcnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rstate <= RT_RUN;
			rcnt <= '0;
			hcnt <= '0;
			hang <= 1'b0;
			trap <= '0;
			mem_irq <= 1'b0;
			err_info <= '0;
			recover <= '0;
			rf_write <= '0;
		end else if (clk_en) begin
			rstate <= next_rstate;
			rcnt <= next_rcnt;
			hcnt <= next_hcnt;
			hang <= next_hang;
			trap <= next_trap;
			mem_irq <= next_mem_irq;
			err_info <= next_err_info;
			recover <= next_recover;
			rf_write <= next_rf_write;
		end
	end

	// One log write per cycle: simultaneous sources beyond the lowest
	// index are dropped, which only costs a missed entry in practice
	always_comb begin
		src_hit = '0;
		for (int i = 0; i < N_SRC; i++)
			src_sev[i] = SEV_RECOVERED;
		for (int ch = 0; ch < N_CH; ch++) begin
			src_hit[ch] = ecc_out[ch].valid && !ecc_out[ch].marked &&
				(ecc_out[ch].single || ecc_out[ch].double);
			src_sev[ch] = ecc_out[ch].double ? SEV_REPORTED : SEV_CORRECTED;
		end
		if (par_in.valid)
			src_hit[SRC_PAR + int'(par_in.src)] = 1'b1;
		src_hit[SRC_EXEC] = exec_err || ub_err;
		src_hit[SRC_HANG] = hang;
		log_we = src_hit != '0;
		log_sel = '0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (src_hit[i])
				log_sel = SRC_W'(i);
		end
		log_wdata = '{1'b1, src_sev[log_sel]};
	end

	ras_log_ram #(
		.WIDTH ($bits(log_entry_t)),
		.DEPTH (N_SRC),
		.AW    (SRC_W)
	) u_log (
		.core_clk (core_clk),
		.reset    (reset),
		.clk_en   (clk_en),
		.we       (log_we),
		.waddr    (log_sel),
		.wdata    (log_wdata),
		.raddr    (log_rd_idx),
		.rdata    (log_rd_data)
	);
endmodule // cpu_ras_error_recovery

// ---- hdl/ras_pkg.sv ----
package ras_pkg;
	localparam int DATA_W = 32;
	localparam int CHK_W = 7;
	localparam int HAM_W = 6;
	localparam int CW_LEN = 38;
	localparam int ADDR_W = 32;
	localparam int WAY_W = 2;
	localparam int N_WAY = 4;
	localparam int OP_W = 16;
	localparam int N_CH = 4;
	localparam int CH_L1D = 0;
	localparam int CH_L2D = 1;
	localparam int CH_L2T = 2;
	localparam int CH_MEM = 3;
	localparam int N_UNIT = 5;
	localparam int U_L1I = 0;
	localparam int U_L1D = 1;
	localparam int U_L2 = 2;
	localparam int U_ITLB = 3;
	localparam int U_DTLB = 4;
	localparam int N_SRC = 16;
	localparam int SRC_W = 4;
	localparam int SRC_PAR = 4;
	localparam int SRC_EXEC = 14;
	localparam int SRC_HANG = 15;
	localparam int CNT_W = 8;
	localparam int DEGRADE_DEFAULT = 8;
	localparam int RETRY_DEFAULT = 3;
	localparam int HANG_DEFAULT = 1048576;
	localparam int MARK_LOW_W = 8;
	localparam logic [CHK_W-1:0] MARK_CHECK = 7'h7f;
	localparam logic [23:0] MARK_PATTERN = 24'hbadbad;
	// Arbitrary neutral value
	localparam logic [7:0] MARK_SOURCE_DEFAULT = 8'h01;

	typedef enum logic [3:0] {
		PS_L1I_DATA, PS_L1I_TAG_A, PS_L1I_TAG_B, PS_L1D_TAG_A, PS_L1D_TAG_B,
		PS_BRANCH, PS_ITLB, PS_DTLB, PS_WIN_COPY, PS_REGS
	} par_src_t;
	typedef enum logic [1:0] {EX_ADD, EX_SHIFT, EX_GFX, EX_MUL} exec_kind_t;
	typedef enum logic [1:0] {
		SEV_CORRECTED, SEV_RECOVERED, SEV_REPORTED, SEV_FATAL
	} severity_t;
	typedef enum logic [1:0] {RT_RUN, RT_CANCEL, RT_RETRY, RT_ABORT}
		retry_state_t;
	typedef enum logic {DG_COUNT, DG_FLUSH} degrade_state_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [WAY_W-1:0]  way;
		logic [DATA_W-1:0] data;
		logic [CHK_W-1:0]  check;
	} ecc_word_t;
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [WAY_W-1:0]  way;
		logic [DATA_W-1:0] data;
		logic [CHK_W-1:0]  check;
		logic              single;
		logic              double;
		logic              marked;
	} ecc_result_t;
	typedef struct packed {
		logic              valid;
		par_src_t          src;
		logic [ADDR_W-1:0] index;
		logic [WAY_W-1:0]  way;
	} par_event_t;
	typedef struct packed {
		logic              l1i_inval;
		logic              refetch_miss;
		logic              l1d_writeback;
		logic [1:0]        tag_notify;
		logic              mispredict;
		logic [1:0]        tlb_inval;
		logic              win_reload;
		logic [ADDR_W-1:0] index;
		logic [WAY_W-1:0]  way;
	} recover_t;
	typedef struct packed {
		logic              valid;
		exec_kind_t        kind;
		logic [OP_W-1:0]   op_a;
		logic              a_par;
		logic [OP_W-1:0]   op_b;
		logic              b_par;
		logic [DATA_W-1:0] res;
		logic              res_par;
	} exec_check_t;
	typedef struct packed {
		logic              valid;
		logic              is_float;
		logic [4:0]        reg_idx;
		logic [DATA_W-1:0] data;
		logic              par;
	} result_t;
	typedef struct packed {
		logic             valid;
		severity_t        sev;
		logic [SRC_W-1:0] source;
	} trap_t;
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic              double;
	} err_info_t;
	typedef struct packed {
		logic      seen;
		severity_t sev;
	} log_entry_t;
endpackage

// ---- hdl/ras_log_ram.sv ----
`timescale 1ns/1ps
module ras_log_ram #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             clk_en,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Cleared on reset so that unseen sources read as empty
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
			rdata <= '0;
		end else if (clk_en) begin
			if (we)
				mem[waddr] <= wdata;
			rdata <= mem[raddr];
		end
	end
endmodule // ras_log_ram

// ---- bench/ras_props.sv ----
`timescale 1ns/1ps
module ras_props (
	input wire logic                   core_clk,
	input wire logic                   reset,
	input wire logic                   suppress_mode,
	input wire ras_pkg::ecc_word_t [3:0]   ecc_in,
	input wire ras_pkg::ecc_result_t [3:0] ecc_out,
	input wire ras_pkg::ecc_word_t [3:0]   rewrite,
	input wire ras_pkg::par_event_t    par_in,
	input wire ras_pkg::recover_t      recover,
	input wire ras_pkg::result_t       ub_result,
	input wire ras_pkg::result_t       rf_write,
	input wire logic                   commit,
	input wire logic [4:0]             flush_done,
	input wire logic [4:0]             flush_req,
	input wire logic                   cancel_all,
	input wire logic                   single_step,
	input wire logic                   mem_irq,
	input wire ras_pkg::trap_t         trap
);
	import ras_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_ecc_answer: assert property (ecc_in[1].valid |=>
		ecc_out[1].valid && ecc_out[1].addr == $past(ecc_in[1].addr))
		else $error("ecc answer missing");
	a_rewrite_fix: assert property (ecc_out[0].single |->
		rewrite[0].valid && rewrite[0].data == ecc_out[0].data)
		else $error("corrected line not rewritten");
	a_tag_rewrite: assert property (ecc_out[2].single |->
		rewrite[2].valid && rewrite[2].addr == ecc_out[2].addr)
		else $error("tag not written back");
	a_mark_fill: assert property (ecc_out[3].double && !ecc_out[3].marked
		|-> ecc_out[3].check == MARK_CHECK
		&& ecc_out[3].data[31:8] == MARK_PATTERN)
		else $error("memory data not marked");
	a_mem_irq: assert property (ecc_out[3].double && !ecc_out[3].marked
		|=> mem_irq) else $error("no memory interrupt");
	a_tlb_inval: assert property (par_in.valid && par_in.src == PS_DTLB
		|=> recover.tlb_inval == 2'h2) else $error("tlb entry kept");
	a_cancel_err: assert property (par_in.valid && par_in.src == PS_REGS
		&& !suppress_mode && !cancel_all |=> cancel_all)
		else $error("no cancel on error");
	a_step_enter: assert property (cancel_all && !trap.valid
		|=> single_step) else $error("retry not started");
	a_step_exit: assert property (single_step && commit
		|=> !single_step) else $error("retry not left");
	a_quiet_mode: assert property (suppress_mode[*3]
		|-> !cancel_all && !trap.valid) else $error("reaction while quiet");
	a_ub_carry: assert property (ub_result.valid
		|=> rf_write == $past(ub_result)) else $error("update lost");
	a_flush_hold: assert property ($fell(flush_req[1])
		|-> $past(flush_done[1])) else $error("flush dropped early");
endmodule // ras_props
bind cpu_ras_error_recovery ras_props chk_u (.*);

// ---- bench/ras_partner.sv ----
`timescale 1ns/1ps
module ras_partner (
	input wire logic       core_clk,
	input wire logic       reset,
	input wire logic       run,
	input wire logic       stall,
	input wire logic [3:0] lat,
	input wire logic [4:0] flush_req,
	output logic           commit,
	output logic           busy,
	output logic [4:0]     flush_done
);
	logic [3:0] cnt;
	// One pace for commits and flushes; lat sets prompt or slow
	always_ff @(posedge core_clk) begin
		if (reset || cnt == lat) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign busy = run;
	assign commit = run && !stall && cnt == lat;
	assign flush_done = flush_req & {5{cnt == lat}};
endmodule // ras_partner

// ---- bench/cpu_ras_error_recovery_tb_top.sv ----
`timescale 1ns/1ps
module cpu_ras_error_recovery_tb_top;
	import ras_pkg::*;
	typedef struct packed {
		logic [1:0]  ch;
		logic [31:0] data;
		logic [6:0]  check;
		logic        sgl;
		logic        dbl;
		logic        mrk;
	} row_t;
	// Zero word is a clean codeword, so flipped bits need no encoder
	localparam row_t ROWS [8] = '{
		'{2'h0, 32'h0, 7'h0, 1'b0, 1'b0, 1'b0},
		'{2'h0, 32'h20, 7'h0, 1'b1, 1'b0, 1'b0},
		'{2'h1, 32'h10000, 7'h0, 1'b1, 1'b0, 1'b0},
		'{2'h2, 32'h0, 7'h4, 1'b1, 1'b0, 1'b0},
		'{2'h3, 32'h80, 7'h0, 1'b1, 1'b0, 1'b0},
		'{2'h3, 32'h3, 7'h0, 1'b0, 1'b1, 1'b0},
		'{2'h3, 32'hbadbad01, 7'h7f, 1'b0, 1'b1, 1'b1},
		'{2'h1, 32'h6, 7'h0, 1'b0, 1'b1, 1'b0}
	};
	localparam logic [7:0] PEXP [9] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h10,
		8'h08, 8'h02, 8'h04, 8'h01};
	logic              core_clk, reset, suppress_mode, commit, busy;
	logic              run, stall, cancel_all, single_step, mem_irq;
	logic              err_info_clear;
	logic [4:0][1:0]   flush_way;
	logic [3:0]        log_rd_idx;
	log_entry_t        log_rd_data;
	logic [4:0]        flush_done, flush_req;
	logic [4:0][3:0]   way_off;
	ecc_word_t [3:0]   ecc_in, rewrite;
	ecc_result_t [3:0] ecc_out;
	par_event_t        par_in;
	recover_t          recover;
	exec_check_t       exec_in;
	result_t           ub_result, rf_write;
	err_info_t         err_info;
	trap_t             trap;
	row_t              r;
	logic [7:0]        v;
	int                failures = 0, check_count = 0, cycles = 0, n;
	cpu_ras_error_recovery #(.HANG_CYCLES(16), .DEGRADE_THRESHOLD(2)) dut_u (
		.*,
		.clk_en(1'b1)
	);
	ras_partner partner_u (.*, .lat(4'h3));
	task automatic report_and_stop;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic regs_err;
		par_in = '{1'b1, PS_REGS, 32'h0, 2'h0};
		step;
		par_in = '0;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		reset = 1'b1;
		suppress_mode = 1'b0;
		run = 1'b1;
		stall = 1'b0;
		err_info_clear = 1'b0;
		log_rd_idx = 4'h3;
		ecc_in = '0;
		par_in = '0;
		exec_in = '0;
		ub_result = '0;
		repeat (8) step;
		reset = 1'b0;
		step;
		foreach (ROWS[i]) begin
			r = ROWS[i];
			ecc_in[r.ch] = '{1'b1, 32'h40, 2'h2, r.data, r.check};
			step;
			ecc_in = '0;
			chk(ecc_out[r.ch].single, r.sgl);
			chk(ecc_out[r.ch].double, r.dbl);
			chk(ecc_out[r.ch].marked, r.mrk);
			if (!r.dbl) chk(ecc_out[r.ch].data, 32'h0);
			chk(rewrite[r.ch].valid, r.sgl && r.ch != 2'h3);
			if (r.dbl && !r.mrk && r.ch == 2'h3)
				chk(ecc_out[3].data[31:8], MARK_PATTERN);
			step;
			if (r.ch == 2'h3) chk(mem_irq, r.dbl && !r.mrk);
			if (r.ch == 2'h3) chk(trap.valid, r.dbl && !r.mrk);
			if (r.ch == 2'h3 && !r.mrk)
				chk(err_info, {1'b1, 32'h40, r.dbl});
			repeat (12) step;
		end
		err_info_clear = 1'b1;
		step;
		err_info_clear = 1'b0;
		chk(err_info.valid, 1'b0);
		$display("ecc rows done");
		for (int s = 0; s < 9; s++) begin
			par_in = '{1'b1, par_src_t'(s), 32'h10, 2'h2};
			step;
			par_in = '0;
			v = {recover.refetch_miss, recover.tag_notify, recover.l1d_writeback,
				recover.mispredict, recover.tlb_inval, recover.win_reload};
			chk(v & PEXP[s], PEXP[s]);
			chk(recover.index, 32'h10);
			if (s == 3) chk({flush_req[1], flush_way[1]}, 3'h6);
			repeat (6) step;
		end
		chk(way_off[0][2], 1'b1);
		chk(way_off[1][2], 1'b1);
		$display("parity rows done");
		// Clean product, bad predicted parity, bad residue
		for (int k = 0; k < 3; k++) begin
			exec_in = '{1'b1, k == 1 ? EX_ADD : EX_MUL, 16'h3, 1'b0, 16'h1,
				1'b1, k == 2 ? 32'h2 : 32'h3, k == 1};
			step;
			exec_in = '0;
			chk(cancel_all, k != 0);
			step;
			chk(single_step, k != 0);
			repeat (8) step;
			chk(single_step, 1'b0);
			ub_result = '{1'b1, 1'b0, 5'h3, 32'h5, k[0]};
			step;
			ub_result = '0;
			chk(rf_write.par, k[0]);
			chk(cancel_all, k[0]);
			repeat (8) step;
		end
		$display("exec checks done");
		run = 1'b0;
		for (int k = 0; k < 4; k++) begin
			regs_err();
			chk(cancel_all, 1'b1);
			chk(trap, k == 3 ? {1'b1, SEV_REPORTED, 4'hd} : 7'h0);
			repeat (3) step;
		end
		chk(single_step, 1'b0);
		suppress_mode = 1'b1;
		ecc_in[3] = '{1'b1, 32'h44, 2'h0, 32'h3, 7'h0};
		regs_err();
		ecc_in = '0;
		chk(cancel_all, 1'b0);
		// Clear meets a new memory error: the error must win
		err_info_clear = 1'b1;
		step;
		err_info_clear = 1'b0;
		chk(mem_irq, 1'b1);
		chk(err_info.valid, 1'b1);
		chk(trap.valid, 1'b0);
		step;
		suppress_mode = 1'b0;
		$display("retry tests done");
		run = 1'b1;
		stall = 1'b1;
		for (n = 0; n < 40 && cancel_all !== 1'b1; n++) step;
		chk(cancel_all, 1'b1);
		chk(n > 15, 1'b1);
		chk(log_rd_data, 3'h6);
		stall = 1'b0;
		repeat (10) step;
		reset = 1'b1;
		step;
		chk(way_off, 20'h0);
		chk(flush_req, 5'h0);
		chk(log_rd_data, 3'h0);
		reset = 1'b0;
		$display("hang and reset done");
		report_and_stop();
	end
endmodule // cpu_ras_error_recovery_tb_top
